// ==== core/i2c_irq_status_and_fifo_counters.sv ====
`timescale 1ns/10ps
// Notes on behaviour
// - one status location; bit meanings chosen by register or fifo mode.
// - writing status clears each flag whose written bit is one.
// - with auto-clear set, any status read clears all flags of the active mode's bank.
// - force bit set drives the interrupt request regardless of flags.
// - register mode: arbitration lost, ready, overrun, general call in bits 3..0.
// - fifo mode keeps seven flags: call, nack, read done, arb, sync, underflow, overflow.
// - fifo mode has one enable bit per each of the seven sources.
// - threshold holds 5-bit receive queue almost-full level, read-write, fifo mode.
// - threshold holds 5-bit transmit queue almost-empty level, programmable.
// - sent byte counter counts bytes sent; write or fifo reset clears it.
// - received byte counter counts stored bytes; write or fifo reset clears it.
// - transmit queue reset: stop after byte if only sending, nack and stop if receiving.
module i2c_irq_status_and_fifo_counters #(
  parameter int COUNT_W = 10
)
(
  input  wire logic                                sys_clk,
  input  wire logic                                rst,
  // system bus slave
  input  wire logic                                sb_csi,
  input  wire logic                                sb_stb,
  input  wire logic                                sb_we,
  input  wire logic [irq_stat_pkg::ADDR_W-1:0]     sb_adr,
  input  wire logic [irq_stat_pkg::DATA_W-1:0]     sb_dati,
  output logic      [irq_stat_pkg::DATA_W-1:0]     sb_dato,
  output logic                                     sb_acko,
  // mode and engine events
  input  wire logic                                fifo_mode,
  input  wire logic                                arbitration_lost_event,
  input  wire logic                                xfer_register_ready_event,
  input  wire logic                                xfer_register_overrun_event,
  input  wire logic                                general_call_event,
  input  wire logic                                nack_received_event,
  input  wire logic                                master_read_done_event,
  input  wire logic                                tx_sync_error_event,
  input  wire logic                                tx_underflow_event,
  input  wire logic                                rx_overflow_event,
  input  wire logic                                tx_byte_sent,
  input  wire logic                                rx_byte_stored,
  input  wire logic                                fifo_rst,
  input  wire logic                                transmit_queue_reset,
  input  wire logic                                engine_transmitting,
  input  wire logic                                engine_receiving,
  // outputs
  output logic                                     irq,
  output logic      [irq_stat_pkg::LEVEL_W-1:0]    rx_almost_full_level,
  output logic      [irq_stat_pkg::LEVEL_W-1:0]    tx_almost_empty_level,
  output logic                                     stop_after_byte_req,
  output logic                                     nack_stop_req
);
  localparam int DW  = irq_stat_pkg::DATA_W;
  localparam int RFW = irq_stat_pkg::REG_FLAG_W;
  localparam int FFW = irq_stat_pkg::FIFO_FLAG_W;
  localparam int LW  = irq_stat_pkg::LEVEL_W;

  irq_stat_pkg::mode_t mode;

  logic          access;
  logic          wr_access;
  logic          rd_access;
  logic [DW-1:0] ctrl_reg;
  logic [DW-1:0] ctrl_next;
  logic [DW-1:0] thresh_reg;
  logic [DW-1:0] thresh_next;
  logic [DW-1:0] dato_reg;
  logic [DW-1:0] dato_next;
  logic          ack_reg;
  logic          ack_next;
  logic          irq_reg;
  logic          irq_next;
  logic          stop_req_reg;
  logic          stop_req_next;
  logic          nack_req_reg;
  logic          nack_req_next;
  logic          auto_clear;
  logic          force_irq_test;
  logic          status_wr;
  logic          status_rd_clear;
  logic [DW-1:0] status_view;
  logic [COUNT_W-1:0] sent_bytes;
  logic [COUNT_W-1:0] received_bytes;

  flag_bank_if #(.W(RFW)) reg_flags_if ();
  flag_bank_if #(.W(FFW)) fifo_flags_if ();

  // the control word's meaning follows the mode as well
  function automatic logic decode_hit(input logic [irq_stat_pkg::ADDR_W-1:0] adr,
                                      input logic [irq_stat_pkg::ADDR_W-1:0] target);
    decode_hit = (adr == target);
  endfunction

  assign mode = fifo_mode ? irq_stat_pkg::MODE_FIFO : irq_stat_pkg::MODE_REGISTER;

  // a request is taken only while no acknowledge is out
  assign access    = sb_csi & sb_stb & ~ack_reg;
  assign wr_access = access & sb_we;
  assign rd_access = access & ~sb_we;

  always_comb
  begin
    auto_clear     = 1'b0;
    force_irq_test = 1'b0;
    unique case (mode)
      irq_stat_pkg::MODE_REGISTER:
      begin
        auto_clear     = ctrl_reg[irq_stat_pkg::REG_AUTO_CLEAR_BIT];
        force_irq_test = ctrl_reg[irq_stat_pkg::REG_FORCE_BIT];
      end
      irq_stat_pkg::MODE_FIFO:
      begin
        auto_clear     = ctrl_reg[irq_stat_pkg::FIFO_AUTO_CLEAR_BIT];
        force_irq_test = ctrl_reg[irq_stat_pkg::FIFO_FORCE_BIT];
      end
    endcase
  end

  assign status_wr       = wr_access & decode_hit(sb_adr, irq_stat_pkg::ADDR_IRQ_STATUS);
  assign status_rd_clear = rd_access & auto_clear & decode_hit(sb_adr, irq_stat_pkg::ADDR_IRQ_STATUS);

  // events only reach the bank of the active mode
  always_comb
  begin
    reg_flags_if.set_events = '0;
    fifo_flags_if.set_events = '0;
    if (mode == irq_stat_pkg::MODE_REGISTER)
    begin
      reg_flags_if.set_events[irq_stat_pkg::REG_ARB_LOST_BIT]     = arbitration_lost_event;
      reg_flags_if.set_events[irq_stat_pkg::REG_XFER_READY_BIT]   = xfer_register_ready_event;
      reg_flags_if.set_events[irq_stat_pkg::REG_XFER_OVERRUN_BIT] = xfer_register_overrun_event;
      reg_flags_if.set_events[irq_stat_pkg::REG_GENERAL_CALL_BIT] = general_call_event;
    end
    else
    begin
      fifo_flags_if.set_events[irq_stat_pkg::FIFO_GENERAL_CALL_BIT] = general_call_event;
      fifo_flags_if.set_events[irq_stat_pkg::FIFO_NACK_BIT]         = nack_received_event;
      fifo_flags_if.set_events[irq_stat_pkg::FIFO_READ_DONE_BIT]    = master_read_done_event;
      fifo_flags_if.set_events[irq_stat_pkg::FIFO_ARB_LOST_BIT]     = arbitration_lost_event;
      fifo_flags_if.set_events[irq_stat_pkg::FIFO_TX_SYNC_ERR_BIT]  = tx_sync_error_event;
      fifo_flags_if.set_events[irq_stat_pkg::FIFO_TX_UNDERFLOW_BIT] = tx_underflow_event;
      fifo_flags_if.set_events[irq_stat_pkg::FIFO_RX_OVERFLOW_BIT]  = rx_overflow_event;
    end
  end

  // clears act on the bank that the shared location currently shows
  always_comb
  begin
    reg_flags_if.clear_mask  = '0;
    fifo_flags_if.clear_mask = '0;
    if (mode == irq_stat_pkg::MODE_REGISTER)
    begin
      if (status_rd_clear)
        reg_flags_if.clear_mask = '1;
      else if (status_wr)
        reg_flags_if.clear_mask = sb_dati[RFW-1:0];
    end
    else
    begin
      if (status_rd_clear)
        fifo_flags_if.clear_mask = '1;
      else if (status_wr)
        fifo_flags_if.clear_mask = sb_dati[FFW-1:0];
    end
  end

  flag_bank #(.W(RFW)) u_reg_flags
  (
    .sys_clk (sys_clk),
    .rst     (rst),
    .fb      (reg_flags_if.bank)
  );

  flag_bank #(.W(FFW)) u_fifo_flags
  (
    .sys_clk (sys_clk),
    .rst     (rst),
    .fb      (fifo_flags_if.bank)
  );

  byte_counter #(.W(COUNT_W)) u_sent_count
  (
    .sys_clk (sys_clk),
    .rst     (rst),
    .clear   (fifo_rst | (wr_access & decode_hit(sb_adr, irq_stat_pkg::ADDR_SENT_BYTE_COUNT))),
    .incr    (tx_byte_sent),
    .count   (sent_bytes)
  );

  byte_counter #(.W(COUNT_W)) u_received_count
  (
    .sys_clk (sys_clk),
    .rst     (rst),
    .clear   (fifo_rst | (wr_access & decode_hit(sb_adr, irq_stat_pkg::ADDR_RECEIVED_BYTE_COUNT))),
    .incr    (rx_byte_stored),
    .count   (received_bytes)
  );

  // status as seen at the shared location
  always_comb
  begin
    status_view = '0;
    if (mode == irq_stat_pkg::MODE_REGISTER)
      status_view[RFW-1:0] = reg_flags_if.flags;
    else
      status_view[FFW-1:0] = fifo_flags_if.flags;
  end

  // register writes
  always_comb
  begin
    ctrl_next   = ctrl_reg;
    thresh_next = thresh_reg;
    if (wr_access && decode_hit(sb_adr, irq_stat_pkg::ADDR_IRQ_ENABLE_CONTROL))
    begin
      // register mode only drives the low byte; upper bits stay put
      if (mode == irq_stat_pkg::MODE_REGISTER)
        ctrl_next[irq_stat_pkg::REG_CTRL_W-1:0] = sb_dati[irq_stat_pkg::REG_CTRL_W-1:0];
      else
        ctrl_next = sb_dati;
    end
    if (wr_access && decode_hit(sb_adr, irq_stat_pkg::ADDR_QUEUE_THRESHOLD))
      thresh_next = sb_dati;
  end

  // read data and acknowledge, one cycle after the request is taken
  always_comb
  begin
    dato_next = dato_reg;
    ack_next  = access;
    if (rd_access)
    begin
      dato_next = '0;
      if (decode_hit(sb_adr, irq_stat_pkg::ADDR_IRQ_ENABLE_CONTROL))
      begin
        if (mode == irq_stat_pkg::MODE_REGISTER)
          dato_next[irq_stat_pkg::REG_CTRL_W-1:0] = ctrl_reg[irq_stat_pkg::REG_CTRL_W-1:0];
        else
          dato_next = ctrl_reg;
      end
      else if (decode_hit(sb_adr, irq_stat_pkg::ADDR_IRQ_STATUS))
        dato_next = status_view;
      else if (decode_hit(sb_adr, irq_stat_pkg::ADDR_QUEUE_THRESHOLD))
        dato_next = thresh_reg;
      else if (decode_hit(sb_adr, irq_stat_pkg::ADDR_SENT_BYTE_COUNT))
        dato_next = DW'(sent_bytes);
      else if (decode_hit(sb_adr, irq_stat_pkg::ADDR_RECEIVED_BYTE_COUNT))
        dato_next = DW'(received_bytes);
    end
  end

  // interrupt request from enabled flags or the test force
  always_comb
  begin
    if (mode == irq_stat_pkg::MODE_REGISTER)
      irq_next = force_irq_test | (|(reg_flags_if.flags & ctrl_reg[RFW-1:0]));
    else
      irq_next = force_irq_test | (|(fifo_flags_if.flags & ctrl_reg[FFW-1:0]));
  end

  // abort of the transmit queue releases the i2c bus cleanly
  always_comb
  begin
    stop_req_next = 1'b0;
    nack_req_next = 1'b0;
    if (transmit_queue_reset || fifo_rst)
    begin
      if (engine_receiving)
        nack_req_next = 1'b1;
      else if (engine_transmitting)
        stop_req_next = 1'b1;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      ctrl_reg     <= irq_stat_pkg::CTRL_RESET;
      thresh_reg   <= irq_stat_pkg::THRESHOLD_RESET;
      dato_reg     <= '0;
      ack_reg      <= 1'b0;
      irq_reg      <= 1'b0;
      stop_req_reg <= 1'b0;
      nack_req_reg <= 1'b0;
    end
    else
    begin
      ctrl_reg     <= ctrl_next;
      thresh_reg   <= thresh_next;
      dato_reg     <= dato_next;
      ack_reg      <= ack_next;
      irq_reg      <= irq_next;
      stop_req_reg <= stop_req_next;
      nack_req_reg <= nack_req_next;
    end
  end

  assign sb_dato               = dato_reg;
  assign sb_acko               = ack_reg;
  assign irq                   = irq_reg;
  assign rx_almost_full_level  = thresh_reg[irq_stat_pkg::THRESH_RX_AF_LSB +: LW];
  assign tx_almost_empty_level = thresh_reg[irq_stat_pkg::THRESH_TX_AE_LSB +: LW];
  assign stop_after_byte_req   = stop_req_reg;
  assign nack_stop_req         = nack_req_reg;
endmodule

// ==== core/irq_stat_pkg.sv ====
package irq_stat_pkg;

  // system bus geometry
  localparam int ADDR_W = 4;
  localparam int DATA_W = 10;

  // register locations on the system bus
  localparam logic [3:0] ADDR_IRQ_ENABLE_CONTROL = 4'h7;
  localparam logic [3:0] ADDR_IRQ_STATUS         = 4'h8;
  localparam logic [3:0] ADDR_QUEUE_THRESHOLD    = 4'h9;
  localparam logic [3:0] ADDR_SENT_BYTE_COUNT    = 4'hA;
  localparam logic [3:0] ADDR_RECEIVED_BYTE_COUNT = 4'hB;

  // operating mode of the controller
  typedef enum logic [0:0] {
    MODE_REGISTER = 1'b0,
    MODE_FIFO     = 1'b1
  } mode_t;

  // control register, register mode layout
  localparam int REG_AUTO_CLEAR_BIT = 7;
  localparam int REG_FORCE_BIT      = 6;
  localparam int REG_CTRL_W         = 8;

  // control register, fifo mode layout
  localparam int FIFO_AUTO_CLEAR_BIT = 9;
  localparam int FIFO_FORCE_BIT      = 8;

  // status and enable positions, register mode
  localparam int REG_FLAG_W           = 4;
  localparam int REG_ARB_LOST_BIT     = 3;
  localparam int REG_XFER_READY_BIT   = 2;
  localparam int REG_XFER_OVERRUN_BIT = 1;
  localparam int REG_GENERAL_CALL_BIT = 0;

  // status and enable positions, fifo mode
  localparam int FIFO_FLAG_W            = 7;
  localparam int FIFO_GENERAL_CALL_BIT  = 6;
  localparam int FIFO_NACK_BIT          = 5;
  localparam int FIFO_READ_DONE_BIT     = 4;
  localparam int FIFO_ARB_LOST_BIT      = 3;
  localparam int FIFO_TX_SYNC_ERR_BIT   = 2;
  localparam int FIFO_TX_UNDERFLOW_BIT  = 1;
  localparam int FIFO_RX_OVERFLOW_BIT   = 0;

  // threshold register layout
  localparam int LEVEL_W           = 5;
  localparam int THRESH_RX_AF_LSB  = 5;
  localparam int THRESH_TX_AE_LSB  = 0;

  // reset values
  localparam logic [9:0] CTRL_RESET      = 10'h000;
  localparam logic [9:0] THRESHOLD_RESET = 10'h000;

  // far-end wait window when finishing a master read, in oscillator periods
  localparam int OSC_WAIT_MIN_PERIODS = 2;
  localparam int OSC_WAIT_MAX_PERIODS = 7;

endpackage

// ==== core/flag_bank_if.sv ====
`timescale 1ns/10ps
interface flag_bank_if #(
  parameter int W = 4
);
  logic [W-1:0] set_events;
  logic [W-1:0] clear_mask;
  logic [W-1:0] flags;

  modport owner
  (
    output set_events,
    output clear_mask,
    input  flags
  );

  modport bank
  (
    input  set_events,
    input  clear_mask,
    output flags
  );
endinterface

// ==== core/flag_bank.sv ====
`timescale 1ns/10ps
module flag_bank #(
  parameter int W = 4
)
(
  input wire logic   sys_clk,
  input wire logic   rst,
  flag_bank_if.bank  fb
);
  logic [W-1:0] flags_reg;
  logic [W-1:0] flags_next;

  // set wins over a clear in the same cycle
  always_comb
  begin
    flags_next = (flags_reg & ~fb.clear_mask) | fb.set_events;
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      flags_reg <= '0;
    else
      flags_reg <= flags_next;
  end

  assign fb.flags = flags_reg;
endmodule

// ==== core/byte_counter.sv ====
`timescale 1ns/10ps
module byte_counter #(
  parameter int W = 10
)
(
  input  wire logic         sys_clk,
  input  wire logic         rst,
  input  wire logic         clear,
  input  wire logic         incr,
  output logic [W-1:0]      count
);
  logic [W-1:0] count_reg;
  logic [W-1:0] count_next;

  // a byte landing in the clearing cycle is still counted; wraps at full scale
  always_comb
  begin
    if (clear)
      count_next = incr ? {{(W-1){1'b0}}, 1'b1} : '0;
    else if (incr)
      count_next = count_reg + 1'b1;
    else
      count_next = count_reg;
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      count_reg <= '0;
    else
      count_reg <= count_next;
  end

  assign count = count_reg;
endmodule

// ==== sim/irq_stat_sva.sv ====
`timescale 1ns/10ps
module irq_stat_sva
(
  input wire logic                             sys_clk,
  input wire logic                             rst,
  input wire logic                             sb_csi,
  input wire logic                             sb_stb,
  input wire logic                             sb_we,
  input wire logic [irq_stat_pkg::ADDR_W-1:0]  sb_adr,
  input wire logic [irq_stat_pkg::DATA_W-1:0]  sb_dati,
  input wire logic [irq_stat_pkg::DATA_W-1:0]  sb_dato,
  input wire logic                             sb_acko,
  input wire logic                             fifo_mode,
  input wire logic                             fifo_rst,
  input wire logic                             transmit_queue_reset,
  input wire logic                             engine_transmitting,
  input wire logic                             engine_receiving,
  input wire logic                             irq,
  input wire logic [irq_stat_pkg::LEVEL_W-1:0] rx_almost_full_level,
  input wire logic [irq_stat_pkg::LEVEL_W-1:0] tx_almost_empty_level,
  input wire logic                             stop_after_byte_req,
  input wire logic                             nack_stop_req
);
  logic take;
  logic rd_st;
  logic qrst;
  assign take = sb_csi && sb_stb && !sb_acko;
  assign rd_st = take && !sb_we && sb_adr == irq_stat_pkg::ADDR_IRQ_STATUS;
  assign qrst = transmit_queue_reset || fifo_rst;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  chk_ack_single_pulse: assert property (take |=> sb_acko ##1 !sb_acko)
    else $error("ack not one cycle after request");
  chk_ack_has_cause: assert property (sb_acko |-> $past(take))
    else $error("ack without request");
  chk_dato_holds: assert property (!$past(take && !sb_we) |-> $stable(sb_dato))
    else $error("read data moved without read");
  chk_unmapped_zero: assert property (take && !sb_we && (sb_adr < irq_stat_pkg::ADDR_IRQ_ENABLE_CONTROL
    || sb_adr > irq_stat_pkg::ADDR_RECEIVED_BYTE_COUNT) |=> sb_dato == 10'h000)
    else $error("unmapped read not zero");
  chk_reg_status_bits: assert property (rd_st && !fifo_mode |=> sb_dato[9:4] == 6'h00)
    else $error("register mode status upper bits set");
  chk_fifo_status_bits: assert property (rd_st && fifo_mode |=> sb_dato[9:7] == 3'h0)
    else $error("fifo mode status upper bits set");
  chk_threshold_levels: assert property (take && sb_we && sb_adr == irq_stat_pkg::ADDR_QUEUE_THRESHOLD |-> ##2
    (rx_almost_full_level == $past(sb_dati[9:5], 2) && tx_almost_empty_level == $past(sb_dati[4:0], 2)))
    else $error("threshold levels wrong");
  chk_abort_rx_nack: assert property (qrst && engine_receiving |=> nack_stop_req && !stop_after_byte_req)
    else $error("no nack stop on receive abort");
  chk_abort_tx_stop: assert property (qrst && !engine_receiving && engine_transmitting |=>
    stop_after_byte_req && !nack_stop_req)
    else $error("no stop on transmit abort");
  chk_abort_idle_quiet: assert property (!(qrst && (engine_receiving || engine_transmitting)) |=>
    !stop_after_byte_req && !nack_stop_req)
    else $error("spurious abort request");
  chk_irq_fall_cause: assert property ($fell(irq) |-> $past(take, 2))
    else $error("irq dropped without bus access");
endmodule

// ==== sim/sb_master.sv ====
`timescale 1ns/10ps
module sb_master
(
  input  wire logic                            sys_clk,
  input  wire logic                            sb_acko,
  input  wire logic [irq_stat_pkg::DATA_W-1:0] sb_dato,
  output logic                                 sb_csi,
  output logic                                 sb_stb,
  output logic                                 sb_we,
  output logic      [irq_stat_pkg::ADDR_W-1:0] sb_adr,
  output logic      [irq_stat_pkg::DATA_W-1:0] sb_dati
);
  int no_ack = 0;
  initial
  begin
    sb_csi = 1'b0;
    sb_stb = 1'b0;
    sb_we = 1'b0;
    sb_adr = 4'h0;
    sb_dati = 10'h000;
  end
  task automatic xfer(input logic we, input logic [3:0] adr, input logic [9:0] wd, output logic [9:0] rd);
    int n;
    @(negedge sys_clk);
    sb_csi = 1'b1;
    sb_stb = 1'b1;
    sb_we = we;
    sb_adr = adr;
    sb_dati = wd;
    n = 0;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (sb_acko !== 1'b1 && n < 8);
    if (sb_acko !== 1'b1)
      no_ack++;
    rd = sb_dato;
    @(negedge sys_clk);
    sb_csi = 1'b0;
    sb_stb = 1'b0;
    // released lines must not keep looking valid
    sb_adr = ~sb_adr;
    sb_dati = ~sb_dati;
    // idle gap kept strictly inside the finishing window of a master read
    repeat (irq_stat_pkg::OSC_WAIT_MIN_PERIODS + 1) @(negedge sys_clk);
  endtask
endmodule

// ==== sim/i2c_irq_status_and_fifo_counters_tb.sv ====
`timescale 1ns/10ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin miscompares++; $display("mismatch t=%0t got=%h exp=%h", $time, (a), (b)); end end
module i2c_irq_status_and_fifo_counters_tb;
  localparam logic [3:0] CT = irq_stat_pkg::ADDR_IRQ_ENABLE_CONTROL;
  localparam logic [3:0] ST = irq_stat_pkg::ADDR_IRQ_STATUS;
  localparam logic [3:0] TH = irq_stat_pkg::ADDR_QUEUE_THRESHOLD;
  localparam logic [3:0] SC = irq_stat_pkg::ADDR_SENT_BYTE_COUNT;
  localparam logic [3:0] RC = irq_stat_pkg::ADDR_RECEIVED_BYTE_COUNT;
  // event index per register mode status bit
  localparam int RMAP [4] = '{6, 8, 7, 3};
  logic       sys_clk = 1'b0;
  logic       rst = 1'b1;
  logic       sb_csi, sb_stb, sb_we, sb_acko, irq, stop_after_byte_req, nack_stop_req;
  logic [3:0] sb_adr;
  logic [9:0] sb_dati, sb_dato;
  logic [4:0] rx_almost_full_level, tx_almost_empty_level;
  logic [8:0] ev = 9'h000;
  logic       fifo_mode = 1'b0, tx_byte_sent = 1'b0, rx_byte_stored = 1'b0, fifo_rst = 1'b0;
  logic       transmit_queue_reset = 1'b0, engine_transmitting = 1'b0, engine_receiving = 1'b0;
  int         checks = 0;
  int         miscompares = 0;
  always #12.5 sys_clk = ~sys_clk;
  sb_master u_sb_master (.sys_clk, .sb_acko, .sb_dato, .sb_csi, .sb_stb, .sb_we, .sb_adr, .sb_dati);
  i2c_irq_status_and_fifo_counters u_i2c_irq_status_and_fifo_counters
  (
    .sys_clk, .rst, .sb_csi, .sb_stb, .sb_we, .sb_adr, .sb_dati, .sb_dato, .sb_acko, .fifo_mode,
    .arbitration_lost_event(ev[3]), .xfer_register_ready_event(ev[7]), .xfer_register_overrun_event(ev[8]),
    .general_call_event(ev[6]), .nack_received_event(ev[5]), .master_read_done_event(ev[4]),
    .tx_sync_error_event(ev[2]), .tx_underflow_event(ev[1]), .rx_overflow_event(ev[0]),
    .tx_byte_sent, .rx_byte_stored, .fifo_rst, .transmit_queue_reset, .engine_transmitting, .engine_receiving,
    .irq, .rx_almost_full_level, .tx_almost_empty_level, .stop_after_byte_req, .nack_stop_req
  );
  task automatic final_report;
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [9:0] d);
    logic [9:0] unused;
    u_sb_master.xfer(1'b1, a, d, unused);
  endtask
  task automatic rd(input logic [3:0] a, input logic [9:0] e);
    logic [9:0] d;
    u_sb_master.xfer(1'b0, a, 10'h000, d);
    `CHK(d, e)
  endtask
  task automatic pulse(input int i);
    @(negedge sys_clk);
    ev[i] = 1'b1;
    @(negedge sys_clk);
    ev[i] = 1'b0;
  endtask
  task automatic flag_pair(input int ia, input int ib, input int ba, input int bb);
    logic [9:0] ma, mb;
    ma = 10'h001 << ba;
    mb = 10'h001 << bb;
    pulse(ia);
    pulse(ib);
    @(negedge sys_clk);
    `CHK(irq, 1'b1)
    rd(ST, ma | mb);
    wr(ST, ma);
    rd(ST, mb);
    wr(ST, mb);
    `CHK(irq, 1'b0)
  endtask
  task automatic abort_chk(input logic rx, input logic tx, input logic en, input logic es);
    @(negedge sys_clk);
    engine_receiving = rx;
    engine_transmitting = tx;
    transmit_queue_reset = 1'b1;
    @(negedge sys_clk);
    transmit_queue_reset = 1'b0;
    `CHK(nack_stop_req, en)
    `CHK(stop_after_byte_req, es)
  endtask
  initial
  begin
    repeat (5) @(negedge sys_clk);
    rst = 1'b0;
    for (int a = 7; a < 12; a++)
      rd(4'(a), 10'h000);
    rd(4'hF, 10'h000);
    wr(CT, 10'h00F);
    for (int b = 0; b < 4; b++)
      flag_pair(RMAP[b], RMAP[(b + 1) % 4], b, (b + 1) % 4);
    wr(CT, 10'h08F);
    rd(CT, 10'h08F);
    pulse(3);
    pulse(6);
    rd(ST, 10'h009);
    rd(ST, 10'h000);
    wr(CT, 10'h040);
    `CHK(irq, 1'b1)
    wr(CT, 10'h000);
    `CHK(irq, 1'b0)
    pulse(3);
    @(negedge sys_clk);
    `CHK(irq, 1'b0)
    wr(ST, 10'h008);
    fifo_mode = 1'b1;
    rd(ST, 10'h000);
    wr(CT, 10'h07F);
    for (int b = 0; b < 7; b++)
      flag_pair(b, (b + 1) % 7, b, (b + 1) % 7);
    pulse(7);
    rd(ST, 10'h000);
    wr(CT, 10'h27F);
    pulse(0);
    pulse(5);
    rd(ST, 10'h021);
    rd(ST, 10'h000);
    wr(CT, 10'h100);
    `CHK(irq, 1'b1)
    wr(CT, 10'h000);
    `CHK(irq, 1'b0)
    wr(CT, 10'h040);
    rd(CT, 10'h040);
    pulse(5);
    @(negedge sys_clk);
    `CHK(irq, 1'b0)
    pulse(6);
    @(negedge sys_clk);
    `CHK(irq, 1'b1)
    wr(ST, 10'h060);
    rd(ST, 10'h000);
    wr(TH, 10'h3A5);
    rd(TH, 10'h3A5);
    `CHK(rx_almost_full_level, 5'h1D)
    `CHK(tx_almost_empty_level, 5'h05)
    @(negedge sys_clk);
    tx_byte_sent = 1'b1;
    rx_byte_stored = 1'b1;
    repeat (2) @(negedge sys_clk);
    rx_byte_stored = 1'b0;
    @(negedge sys_clk);
    tx_byte_sent = 1'b0;
    rd(SC, 10'h003);
    rd(RC, 10'h002);
    wr(SC, 10'h3FF);
    rd(SC, 10'h000);
    rd(RC, 10'h002);
    @(negedge sys_clk);
    fifo_rst = 1'b1;
    tx_byte_sent = 1'b1;
    @(negedge sys_clk);
    fifo_rst = 1'b0;
    tx_byte_sent = 1'b0;
    rd(SC, 10'h001);
    rd(RC, 10'h000);
    abort_chk(1'b1, 1'b1, 1'b1, 1'b0);
    abort_chk(1'b0, 1'b1, 1'b0, 1'b1);
    abort_chk(1'b0, 1'b0, 1'b0, 1'b0);
    `CHK(u_sb_master.no_ack, 0)
    final_report;
  end
  initial
  begin
    repeat (5000) @(posedge sys_clk);
    miscompares++;
    final_report;
  end
endmodule
bind i2c_irq_status_and_fifo_counters irq_stat_sva u_irq_stat_sva
(
  .sys_clk, .rst, .sb_csi, .sb_stb, .sb_we, .sb_adr, .sb_dati, .sb_dato, .sb_acko, .fifo_mode, .fifo_rst,
  .transmit_queue_reset, .engine_transmitting, .engine_receiving, .irq, .rx_almost_full_level,
  .tx_almost_empty_level, .stop_after_byte_req, .nack_stop_req
);
